// ==== nv_store.sv ====
/*
 * nonvolatile word store: setpoint table, other calibration words and
 * the lock word. one write or read port, read data from a register.
 * assumes requests come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "prog_lock_params.svh"

module nv_store
   import prog_lock_pkg::*;
(
   input wire logic clk_sys_in,
   input wire mem_req_s req_in,
   output logic [`DATA_W-1:0] rdata_out
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // the array has no reset: its content must survive any reset
   logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];

   // blank part as delivered, lock word clear
   initial
   begin
      for (int i = 0; i < (1<<`ADDR_W); i++)
      begin
         mem[i] = `MEM_RESET_WORD;
      end
   end

   // write-first is not needed: read data from a write cycle is never used
   always_ff @(posedge clk_sys_in)
   begin
      if (req_in.we)
      begin
         mem[req_in.addr] <= req_in.wdata;
      end
      rdata_out <= mem[req_in.addr];
   end

endmodule : nv_store

`default_nettype wire

// ==== prog_lock_params.svh ====
/*
 * constants of the supply-modulated programming and lock control:
 * timing figures, memory layout, telegram layout and reset values.
 * assumes a 20 MHz system clock; included by bare name.
 */
`ifndef PROG_LOCK_PARAMS_SVH
`define PROG_LOCK_PARAMS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define CLK_MHZ 20
`define TELE_BIT_US 1000
`define TELE_BIT_CYC (`TELE_BIT_US * `CLK_MHZ)
`define BIPH_BIT_US 40
`define BIPH_BIT_CYC (`BIPH_BIT_US * `CLK_MHZ)
`define PWM_PERIOD_US 1000
`define PWM_STEPS 4096
`define PWM_STEP_CYC ((`PWM_PERIOD_US * `CLK_MHZ) / `PWM_STEPS)

// ---------------------------------------------------------------
// memory and telegram layout
// ---------------------------------------------------------------
`define ADDR_W 6
`define DATA_W 9
`define SETPOINTS 32
`define LOCK_ADDR 6'h3f
`define LOCK_BIT 0
`define FRAME_BITS 16
`define WRITE_POS 15
`define MEAS_W 12
`define MEM_RESET_WORD 9'h000

`endif

// ==== prog_lock_pkg.sv ====
/*
 * types of the supply-modulated programming and lock control.
 * assumes prog_lock_params.svh is on the include path.
 */
`include "prog_lock_params.svh"

package prog_lock_pkg;

   // ------------------------------------------------------------
   // control states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      BOOT_REQ,
      BOOT_WAIT,
      BOOT_LOAD,
      IDLE,
      RX,
      EXEC,
      RD_WAIT,
      TX
   } fsm_e;

   // one received telegram: write flag, address, data
   typedef struct packed {
      logic write;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] data;
   } cmd_s;

   // memory request towards the nonvolatile store
   typedef struct packed {
      logic we;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] wdata;
   } mem_req_s;

   // whole state of the control block
   typedef struct packed {
      fsm_e st;
      logic busy;
      logic lock;
      logic [15:0] cnt;
      logic [4:0] bitn;
      logic [`FRAME_BITS-1:0] shreg;
      logic [`DATA_W-1:0] tx;
      logic [3:0] txn;
      logic vdd_s1;
      logic vdd_s2;
      logic vdd_d;
      logic ok_s1;
      logic ok_s2;
      logic cur_mod;
      logic data;
      logic data_oe;
      logic meas_en;
      logic meas;
      logic blev;
      logic [15:0] ocnt;
      logic [3:0] obit;
      logic [`MEAS_W-1:0] oword;
      logic [`MEAS_W-1:0] pcnt;
      mem_req_s mem;
   } core_s;

endpackage : prog_lock_pkg

// ==== prog_lock_sva.sv ====
/*
 * checker for the programming and lock control.
 * assumes it sees only the top module's ports; bound below.
 */
`timescale 1ns/10ps
`default_nettype none
`include "prog_lock_params.svh"

module prog_lock_sva
   import prog_lock_pkg::*;
#(
   parameter int TELE_BIT_CYC = 40,
   parameter int BIPH_BIT_CYC = 16,
   parameter int PWM_STEP_CYC = 4
)
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic vdd_high_in,
   input wire logic supply_ok_in,
   input wire logic biphase_sel_in,
   input wire logic [`MEAS_W-1:0] meas_word_in,
   input wire logic cur_mod_out,
   input wire logic meas_en_out,
   input wire logic meas_out,
   input wire logic data_out,
   input wire logic data_oe_out,
   input wire logic locked_out,
   input wire logic busy_out
);
   logic [15:0] hi_cnt;

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   // -----------------------------------------------------------
   // answer bit length
   // -----------------------------------------------------------
   // length of the current high run on the answer line
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in || !cur_mod_out)
         hi_cnt <= 16'h0000;
      else
         hi_cnt <= hi_cnt + 16'h0001;
   end

   // -----------------------------------------------------------
   // properties
   // -----------------------------------------------------------
   // registered flags may trail the state by one cycle
   property p_busy_quiet;
      busy_out && $past(busy_out) |-> !meas_en_out;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("measurement on while busy");
   property p_meas_zero;
      !meas_en_out && !$past(meas_en_out) |-> !meas_out;
   endproperty
   a_meas_zero: assert property (p_meas_zero)
      else $error("measurement line active while off");
   property p_meas_on;
      (!busy_out && supply_ok_in)[*4] |-> meas_en_out;
   endproperty
   a_meas_on: assert property (p_meas_on)
      else $error("measurement not enabled when idle");
   property p_lock_hold;
      locked_out |=> locked_out;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lock cleared");
   property p_lock_rise;
      $rose(locked_out) |-> $past(busy_out);
   endproperty
   a_lock_rise: assert property (p_lock_rise)
      else $error("lock set outside boot or command");
   property p_oe_locked;
      locked_out && $past(locked_out) |-> !data_oe_out;
   endproperty
   a_oe_locked: assert property (p_oe_locked)
      else $error("data pin driven while locked");
   property p_pin_copy;
      data_oe_out |-> data_out == cur_mod_out;
   endproperty
   a_pin_copy: assert property (p_pin_copy)
      else $error("data pin differs from answer");
   property p_idle_quiet;
      !busy_out && !$past(busy_out) |-> !cur_mod_out;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("current modulated while idle");
   property p_bit_len;
      $fell(cur_mod_out) |-> (hi_cnt % TELE_BIT_CYC) == 0;
   endproperty
   a_bit_len: assert property (p_bit_len)
      else $error("answer bit of wrong length");
   property p_boot;
      $fell(sys_rst_in) |-> ##[2:8] !busy_out;
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot did not finish");

endmodule : prog_lock_sva

bind supply_modulated_programming_lock prog_lock_sva #(.TELE_BIT_CYC(TELE_BIT_CYC),
   .BIPH_BIT_CYC(BIPH_BIT_CYC), .PWM_STEP_CYC(PWM_STEP_CYC)) prog_lock_sva_inst (
   .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .vdd_high_in(vdd_high_in),
   .supply_ok_in(supply_ok_in), .biphase_sel_in(biphase_sel_in), .meas_word_in(meas_word_in),
   .cur_mod_out(cur_mod_out), .meas_en_out(meas_en_out), .meas_out(meas_out),
   .data_out(data_out), .data_oe_out(data_oe_out), .locked_out(locked_out),
   .busy_out(busy_out));

`default_nettype wire

// ==== prog_master.sv ====
/*
 * programmer model: sends telegrams on the supply level and reads
 * the current answer. assumes the answer timing of the control block.
 */
`timescale 1ns/10ps
`default_nettype none

module prog_master
   import prog_lock_pkg::*;
#(
   parameter int T = 40
)
(
   input wire logic clk_sys_in,
   input wire logic cur_mod_in,
   output logic vdd_high_out
);
   initial vdd_high_out = 1'b0;

   // -----------------------------------------------------------
   // one exchange
   // -----------------------------------------------------------
   // answer sampled mid-bit, so sync latency never matters
   task automatic xfer(input logic [15:0] frame, input int nbits, output logic [8:0] ans);
      int i;
      @(negedge clk_sys_in);
      vdd_high_out = 1'b1;
      repeat (T) @(negedge clk_sys_in);
      for (i = 15; i >= 0; i--)
      begin
         vdd_high_out = frame[i];
         repeat (T) @(negedge clk_sys_in);
      end
      vdd_high_out = 1'b0;
      repeat (5) @(negedge clk_sys_in);
      ans = 9'h000;
      for (i = 0; i < nbits; i++)
      begin
         ans = {ans[7:0], cur_mod_in};
         repeat (T) @(negedge clk_sys_in);
      end
   endtask : xfer

endmodule : prog_master

`default_nettype wire

// ==== supply_modulated_programming_lock.sv ====
/*
 * programming and lock control of a programmable linear sensor.
 * commands arrive as supply level changes, answers leave as current
 * modulation; a one-time lock ends programming and the data pin.
 * assumes vdd_high_in and supply_ok_in come from analog comparators
 * (asynchronous), meas_word_in and biphase_sel_in from logic on clk_sys_in.
 */
`timescale 1ns/10ps
`default_nettype none
`include "prog_lock_params.svh"

// Function
// - lock set refuses all writes, never cleared
// - unlocked device accepts setpoint and calibration writes
// - execute read or write, answer via current
// - no measurement output during programming exchange
// - idle with good supply enables measurement output
// - data pin only active while unlocked
// - output table of 32 nine-bit setpoints
// - biphase zero flat, one mid toggle, edge
module supply_modulated_programming_lock
   import prog_lock_pkg::*;
#(
   parameter int TELE_BIT_CYC = `TELE_BIT_CYC,
   parameter int BIPH_BIT_CYC = `BIPH_BIT_CYC,
   parameter int PWM_STEP_CYC = `PWM_STEP_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic vdd_high_in,
   input wire logic supply_ok_in,
   input wire logic biphase_sel_in,
   input wire logic [`MEAS_W-1:0] meas_word_in,
   output logic cur_mod_out,
   output logic meas_en_out,
   output logic meas_out,
   output logic data_out,
   output logic data_oe_out,
   output logic locked_out,
   output logic busy_out
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // counters are 16 bits wide; the mid toggle needs a few cycles
   if (TELE_BIT_CYC < 4 || TELE_BIT_CYC > 40000)
   begin : bad_tele
      $error("telegram bit time out of counter range");
   end
   if (BIPH_BIT_CYC < 8 || BIPH_BIT_CYC > 65535)
   begin : bad_biph
      $error("biphase bit time out of counter range");
   end
   // the pwm step shares the bit counter, so it must wrap before the bit end
   if (PWM_STEP_CYC < 1 || PWM_STEP_CYC >= BIPH_BIT_CYC)
   begin : bad_pwm
      $error("pwm step out of shared counter range");
   end
   if (`SETPOINTS > (1 << `ADDR_W) - 1)
   begin : bad_table
      $error("setpoint table collides with lock word");
   end

   // ---------------------------------------------------------------
   // derived counts
   // ---------------------------------------------------------------
   localparam logic [15:0] TBIT_LAST = 16'(TELE_BIT_CYC - 1);
   // first sample in the middle of the first bit after the start bit
   localparam logic [15:0] TFIRST = 16'(TELE_BIT_CYC + TELE_BIT_CYC / 2 - 1);
   localparam logic [15:0] BBIT_LAST = 16'(BIPH_BIT_CYC - 1);
   // mid toggle at 5/8 of the bit, inside the 50..80 % window
   localparam logic [15:0] BMID = 16'((BIPH_BIT_CYC * 5) / 8);
   localparam logic [15:0] PSTEP_LAST = 16'(PWM_STEP_CYC - 1);
   localparam logic [4:0] LAST_BIT = 5'(`FRAME_BITS - 1);

   // ---------------------------------------------------------------
   // state and store
   // ---------------------------------------------------------------
   core_s r;
   core_s next_r;
   cmd_s cmd;
   logic [`DATA_W-1:0] rdata;

   nv_store u_store (
      .clk_sys_in(clk_sys_in),
      .req_in(r.mem),
      .rdata_out(rdata)
   );

   assign cmd = r.shreg;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      // two-stage synchronisers; the second stage is looked at, and vdd_d with it for the supply edge
      next_r.vdd_s1 = vdd_high_in;
      next_r.vdd_s2 = r.vdd_s1;
      next_r.vdd_d = r.vdd_s2;
      next_r.ok_s1 = supply_ok_in;
      next_r.ok_s2 = r.ok_s1;
      next_r.mem.we = 1'b0;

      unique case (r.st)
         // lock word fetched before the receiver is armed
         BOOT_REQ:
         begin
            next_r.mem.addr = `LOCK_ADDR;
            next_r.st = BOOT_WAIT;
         end
         BOOT_WAIT:
         begin
            next_r.st = BOOT_LOAD;
         end
         BOOT_LOAD:
         begin
            next_r.lock = rdata[`LOCK_BIT];
            next_r.st = IDLE;
         end
         // a rising supply level opens a telegram
         IDLE:
         begin
            if (r.vdd_s2 && !r.vdd_d)
            begin
               next_r.cnt = TFIRST;
               next_r.bitn = 5'h00;
               next_r.st = RX;
            end
         end
         // sample supply level once per bit, msb first
         RX:
         begin
            if (r.cnt == 16'h0000)
            begin
               next_r.shreg = {r.shreg[`FRAME_BITS-2:0], r.vdd_s2};
               next_r.bitn = r.bitn + 5'h01;
               next_r.cnt = TBIT_LAST;
               if (r.bitn == LAST_BIT)
               begin
                  // address goes out early: the store needs a cycle before RD_WAIT
                  next_r.mem.addr = r.shreg[`FRAME_BITS-3 -: `ADDR_W];
                  next_r.st = EXEC;
               end
            end
            else
            begin
               next_r.cnt = r.cnt - 16'h0001;
            end
         end
         // carry out the command
         EXEC:
         begin
            next_r.mem.addr = cmd.addr;
            if (cmd.write)
            begin
               // a locked store answers with a zero acknowledge
               if (!r.lock)
               begin
                  next_r.mem.we = 1'b1;
                  next_r.mem.wdata = cmd.data;
                  if (cmd.addr == `LOCK_ADDR && cmd.data[`LOCK_BIT])
                  begin
                     next_r.lock = 1'b1;
                  end
               end
               next_r.tx = {!r.lock, 8'h00};
               next_r.txn = 4'h1;
               next_r.cur_mod = !r.lock;
               next_r.cnt = TBIT_LAST;
               next_r.st = TX;
            end
            else
            begin
               next_r.st = RD_WAIT;
            end
         end
         RD_WAIT:
         begin
            next_r.tx = rdata;
            next_r.txn = 4'(`DATA_W);
            next_r.cur_mod = rdata[`DATA_W-1];
            next_r.cnt = TBIT_LAST;
            next_r.st = TX;
         end
         // answer by current draw, one bit time per bit
         TX:
         begin
            if (r.cnt == 16'h0000)
            begin
               next_r.cnt = TBIT_LAST;
               next_r.tx = {r.tx[`DATA_W-2:0], 1'b0};
               next_r.txn = r.txn - 4'h1;
               if (r.txn == 4'h1)
               begin
                  next_r.cur_mod = 1'b0;
                  next_r.st = IDLE;
               end
               else
               begin
                  next_r.cur_mod = r.tx[`DATA_W-2];
               end
            end
            else
            begin
               next_r.cnt = r.cnt - 16'h0001;
            end
         end
      endcase

      // data pin mirrors the answer, but only while unlocked
      next_r.data_oe = !next_r.lock && (next_r.st == TX);
      next_r.data = next_r.data_oe & next_r.cur_mod;

      // free-running frame generators; words latched per frame
      if (r.ocnt == BBIT_LAST)
      begin
         next_r.ocnt = 16'h0000;
         next_r.blev = !r.blev;
         if (r.obit == 4'h0)
         begin
            next_r.obit = 4'(`MEAS_W - 1);
            next_r.oword = meas_word_in;
         end
         else
         begin
            next_r.obit = r.obit - 4'h1;
         end
      end
      else
      begin
         next_r.ocnt = r.ocnt + 16'h0001;
         if (r.ocnt == BMID && r.oword[r.obit])
         begin
            next_r.blev = !r.blev;
         end
      end
      // pwm shares the word latch; a step counter sets resolution
      if (!biphase_sel_in && r.ocnt >= PSTEP_LAST)
      begin
         next_r.ocnt = 16'h0000;
         next_r.pcnt = r.pcnt + 12'h001;
         if (r.pcnt == 12'hfff)
         begin
            next_r.oword = meas_word_in;
         end
      end

      // measurement only when idle and the supply is normal
      next_r.meas_en = (next_r.st == IDLE) && r.ok_s2;
      next_r.busy = (next_r.st != IDLE);
      if (!next_r.meas_en)
      begin
         next_r.meas = 1'b0;
      end
      else if (biphase_sel_in)
      begin
         next_r.meas = next_r.blev;
      end
      else
      begin
         next_r.meas = (r.pcnt < r.oword);
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // reset clears the whole state, lock copy included; it is reloaded before any command
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // outputs straight from the state register
   // ---------------------------------------------------------------
   assign cur_mod_out = r.cur_mod;
   assign meas_en_out = r.meas_en;
   assign meas_out = r.meas;
   assign data_out = r.data;
   assign data_oe_out = r.data_oe;
   assign locked_out = r.lock;
   assign busy_out = r.busy; // registered copy of the state test

endmodule : supply_modulated_programming_lock

`default_nettype wire

// ==== testbench.sv ====
/*
 * testbench of the programming and lock control.
 * assumes the programmer model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
`include "prog_lock_params.svh"

module testbench
   import prog_lock_pkg::*;
;
   logic clk_sys_in, sys_rst_in, vdd_high_in, supply_ok_in, biphase_sel_in;
   logic [`MEAS_W-1:0] meas_word_in;
   logic cur_mod_out, meas_en_out, meas_out, data_out, data_oe_out, locked_out, busy_out;
   int n_mismatch, samples_checked;
   int n_oe, n_dat;

   supply_modulated_programming_lock #(.TELE_BIT_CYC(40), .BIPH_BIT_CYC(16), .PWM_STEP_CYC(1))
      supply_modulated_programming_lock_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .vdd_high_in(vdd_high_in), .supply_ok_in(supply_ok_in), .biphase_sel_in(biphase_sel_in),
      .meas_word_in(meas_word_in), .cur_mod_out(cur_mod_out), .meas_en_out(meas_en_out),
      .meas_out(meas_out), .data_out(data_out), .data_oe_out(data_oe_out),
      .locked_out(locked_out), .busy_out(busy_out));
   prog_master #(.T(40)) prog_master_inst (.clk_sys_in(clk_sys_in), .cur_mod_in(cur_mod_out),
      .vdd_high_out(vdd_high_in));

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   initial
   begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   // free-running counts of data pin drive and high level
   always @(negedge clk_sys_in)
   begin
      if (data_oe_out === 1'b1) n_oe++;
      if (data_out === 1'b1) n_dat++;
   end

   task test_done;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // bounded wait, a hang ends the run
   task wait_idle;
      int i;
      for (i = 0; i < 2000 && busy_out !== 1'b0; i++) @(negedge clk_sys_in);
      if (busy_out !== 1'b0)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t busy stuck", $time);
         test_done();
      end
      repeat (3) @(negedge clk_sys_in);
   endtask : wait_idle

   task do_rst;
      sys_rst_in = 1'b1;
      repeat (6) @(negedge clk_sys_in);
      sys_rst_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      wait_idle();
   endtask : do_rst

   task wr(input logic [5:0] a, input logic [8:0] d, input logic ack);
      logic [8:0] ans;
      prog_master_inst.xfer({1'b1, a, d}, 1, ans);
      check(ans, ack);
      wait_idle();
   endtask : wr

   task rd(input logic [5:0] a, input logic [8:0] exp);
      logic [8:0] ans;
      prog_master_inst.xfer({1'b0, a, 9'h000}, 9, ans);
      check(ans, exp);
      wait_idle();
   endtask : rd

   // window of whole output periods (two for pwm, one for biphase), so phase does not matter
   task count_meas(input logic sel, input logic [11:0] w, input int win, output int n);
      int i;
      logic prev;
      biphase_sel_in = sel;
      meas_word_in = w;
      repeat (2 * win) @(negedge clk_sys_in);
      n = 0;
      prev = meas_out;
      for (i = 0; i < win; i++)
      begin
         @(negedge clk_sys_in);
         if (sel ? (meas_out !== prev) : (meas_out === 1'b1))
            n++;
         prev = meas_out;
      end
   endtask : count_meas

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task t_boot;
      do_rst();
      check(locked_out, 1'b0);
      check(meas_en_out, 1'b1);
   endtask : t_boot

   task t_prog;
      int oe0, dat0;
      oe0 = n_oe;
      dat0 = n_dat;
      wr(6'h05, 9'h1a5, 1'b1);
      check(16'(n_oe - oe0), 16'd40);
      check(16'(n_dat - dat0), 16'd40);
      wr(6'h1f, 9'h1ff, 1'b1);
      rd(6'h05, 9'h1a5);
      rd(6'h1f, 9'h1ff);
   endtask : t_prog

   task t_pwm;
      int n;
      count_meas(1'b0, 12'h123, 8192, n);
      check(n[15:0], 16'd582);
   endtask : t_pwm

   task t_biph;
      int n;
      count_meas(1'b1, 12'ha5c, 192, n);
      check(n[15:0], 16'd18);
   endtask : t_biph

   task t_supply;
      supply_ok_in = 1'b0;
      repeat (5) @(negedge clk_sys_in);
      check(meas_en_out, 1'b0);
      check(meas_out, 1'b0);
      supply_ok_in = 1'b1;
      repeat (5) @(negedge clk_sys_in);
      check(meas_en_out, 1'b1);
   endtask : t_supply

   task t_lock;
      int oe0;
      oe0 = n_oe;
      wr(6'h3f, 9'h001, 1'b1);
      check(locked_out, 1'b1);
      wr(6'h05, 9'h000, 1'b0);
      wr(6'h3f, 9'h000, 1'b0);
      rd(6'h05, 9'h1a5);
      check(locked_out, 1'b1);
      check(16'(n_oe - oe0), 16'h0000);
      do_rst();
      check(locked_out, 1'b1);
      rd(6'h05, 9'h1a5);
   endtask : t_lock

   // main sequence
   initial
   begin
      n_mismatch = 0;
      samples_checked = 0;
      sys_rst_in = 1'b1;
      supply_ok_in = 1'b1;
      biphase_sel_in = 1'b0;
      meas_word_in = 12'h123;
      t_boot();
      t_prog();
      t_pwm();
      t_biph();
      t_supply();
      t_lock();
      test_done();
   end

endmodule : testbench

`default_nettype wire
